// ### src/psc_channel.sv
`timescale 1ns/1ns
// One output channel: holds on/off, freezes it while low power is held
module psc_channel
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic kill_i,
    input wire logic freeze_i,
    input wire logic fallback_i,
    input wire logic fallback_level_i,
    input wire logic switch_bit_i,
    input wire logic short_i,
    output logic on_o
);

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || kill_i)
            on_o <= 1'b0;
        else if (short_i && on_o)
            on_o <= 1'b0;
        else if (fallback_i)
            on_o <= fallback_level_i;
        else if (!freeze_i)
            on_o <= switch_bit_i;
    end

endmodule

// ### src/psc_controller.sv
`timescale 1ns/1ns
`include "psc_defines.svh"
// Function
// - Pairing setting writable only while outputs are off.
// - Configuration registers hold their contents through low power.
// - Chip select low wakes from sleep; init and checks precede configure.
// - Fallback entry follows watchdog failure or fallback request input.
// - Battery undervoltage turns channels off and sets its fault bit.
// - Battery lost, logic valid: core runs, registers kept, channels off, SPI served.
// - Both supplies low: channels off, registers reset, SPI refused.
// - Logic supply low, battery valid: fallback, registers kept, SPI refused.
// - Both supplies valid: channels follow register writes, SPI served.
// - Reset flag is set after digital reset; host rewrites configuration.
// - Host writes switch state first, then low-power write enters low power.
// - No channel changes on or off entering or during low power, except turn-off by a short or battery loss.
// - Low-power entry completes only once enabled channels are fully on.
// - Channel off in low power turns on only after return to active.
// - A write of 0 to the low-power bit or an automatic wake leaves low power.
// - Reading the low-power status bit in active state releases the wake output.
// - Load current above the programmed threshold wakes to active.
// - Automatic wake pulls the active-low wake output low.
// - Overcurrent fault recorded after wake only if confirmed in active.
// - After automatic wake low-power bit stays 1; rewrite 0 then 1.
// - Logic supply loss in low power goes to sleep, losing configuration.
// - Short-circuit protection stays active for channels on in low power.
// - Leave fallback only after request low and host writes 1 to status.
module psc_controller
#(
    parameter int CHANNELS = 2
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic select_input_low_i,
    input wire logic battery_supply_ok_i,
    input wire logic logic_supply_ok_i,
    input wire logic fallback_request_input_i,
    input wire logic watchdog_fail_i,
    input wire logic wr_en_i,
    input wire logic wr_switch_i,
    input wire logic [CHANNELS-1:0] wr_switch_data_i,
    input wire logic wr_pairing_i,
    input wire logic wr_pairing_data_i,
    input wire logic wr_low_power_i,
    input wire logic wr_low_power_data_i,
    input wire logic [1:0] wr_wake_thr_i,
    input wire logic wr_fallback_stat_i,
    input wire logic rd_status_i,
    input wire logic [CHANNELS-1:0] fallback_level_i,
    input wire logic [CHANNELS-1:0] fully_on_i,
    input wire logic [CHANNELS-1:0] load_above_thr_i,
    input wire logic [CHANNELS-1:0] short_i,
    input wire logic [CHANNELS-1:0] overcurrent_i,
    output psc_pkg::psc_state_t state_o,
    output logic [CHANNELS-1:0] channel_on_o,
    output logic spi_ready_o,
    output logic pairing_o,
    output logic low_power_bit_o,
    output logic [1:0] wake_thr_o,
    output logic [CHANNELS-1:0] switch_state_o,
    output logic [`PSC_FLT_WIDTH-1:0] global_fault_type_o,
    output logic fault_wake_output_n_o
);

    localparam int INIT_CYC = `PSC_INIT_CYCLES;
    localparam int ABIST_CYC = `PSC_ABIST_CYCLES;

    psc_pkg::psc_state_t state;
    psc_pkg::psc_state_t next_state;
    logic [7:0] timer;
    logic core_reset;
    logic spi_ok;
    logic wr_ok;
    logic auto_wake;
    logic lp_exit_cmd;
    logic lp_enter_cmd;
    logic lp_armed;
    logic kill;
    logic freeze;
    logic fallback;
    logic [CHANNELS-1:0] on;

    // Digital core is lost when both supplies are down or logic supply drops in low power
    assign core_reset = rst_i || (!battery_supply_ok_i && !logic_supply_ok_i)
        || (state == psc_pkg::PSC_LOW_POWER && !logic_supply_ok_i);
    assign spi_ok = logic_supply_ok_i && state != psc_pkg::PSC_SLEEP
        && state != psc_pkg::PSC_INIT && state != psc_pkg::PSC_FALLBACK;
    assign wr_ok = spi_ok && wr_en_i;
    assign lp_exit_cmd = wr_ok && wr_low_power_i && !wr_low_power_data_i;
    assign lp_enter_cmd = wr_ok && wr_low_power_i && wr_low_power_data_i && lp_armed;
    assign auto_wake = |(load_above_thr_i & on);

    always_comb
    begin
        next_state = state;
        case (state)
            psc_pkg::PSC_SLEEP:
                if (!select_input_low_i && logic_supply_ok_i)
                    next_state = psc_pkg::PSC_INIT;
            psc_pkg::PSC_INIT:
                if (timer == 8'(INIT_CYC - 1))
                    next_state = psc_pkg::PSC_ACTIVE;
            psc_pkg::PSC_ACTIVE:
                if (!logic_supply_ok_i || fallback_request_input_i || watchdog_fail_i)
                    next_state = psc_pkg::PSC_FALLBACK;
                else if (!battery_supply_ok_i)
                    next_state = psc_pkg::PSC_VBB_UV;
                else if (lp_enter_cmd)
                    next_state = psc_pkg::PSC_LP_ENTRY;
            psc_pkg::PSC_LP_ENTRY:
                if (lp_exit_cmd)
                    next_state = psc_pkg::PSC_ACTIVE;
                else if ((on & ~fully_on_i) == '0)
                    next_state = psc_pkg::PSC_LOW_POWER;
            psc_pkg::PSC_LOW_POWER:
                if (lp_exit_cmd || auto_wake)
                    next_state = psc_pkg::PSC_LP_EXIT;
            psc_pkg::PSC_LP_EXIT:
                if (timer == 8'(ABIST_CYC - 1))
                    next_state = psc_pkg::PSC_ACTIVE;
            psc_pkg::PSC_VBB_UV:
                if (battery_supply_ok_i)
                    next_state = psc_pkg::PSC_ACTIVE;
            psc_pkg::PSC_FALLBACK:
                if (logic_supply_ok_i && !fallback_request_input_i && !watchdog_fail_i
                    && wr_en_i && wr_fallback_stat_i)
                    next_state = psc_pkg::PSC_ACTIVE;
            default:
                next_state = psc_pkg::PSC_SLEEP;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (core_reset)
            state <= psc_pkg::PSC_SLEEP;
        else
            state <= next_state;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (core_reset || next_state != state)
            timer <= 8'h00;
        else if (state == psc_pkg::PSC_INIT || state == psc_pkg::PSC_LP_EXIT)
            timer <= timer + 8'h01;
    end

    // Configuration: kept through low power, undervoltage and fallback
    always_ff @(posedge sys_clk_i)
    begin
        if (core_reset)
        begin
            pairing_o <= `PSC_PAIRING_RESET;
            switch_state_o <= `PSC_SWITCH_RESET;
            wake_thr_o <= `PSC_WAKE_THR_RESET;
        end
        else if (wr_ok && state == psc_pkg::PSC_ACTIVE)
        begin
            if (wr_pairing_i && on == '0)
                pairing_o <= wr_pairing_data_i;
            if (wr_switch_i)
                switch_state_o <= wr_switch_data_i;
            if (wr_low_power_i)
                wake_thr_o <= wr_wake_thr_i;
        end
    end

    // Low-power bit stays 1 after an automatic wake until written 0
    always_ff @(posedge sys_clk_i)
    begin
        if (core_reset)
        begin
            low_power_bit_o <= 1'b0;
            lp_armed <= 1'b1;
        end
        else if (wr_ok && wr_low_power_i)
        begin
            low_power_bit_o <= wr_low_power_data_i;
            lp_armed <= !wr_low_power_data_i || (state != psc_pkg::PSC_ACTIVE);
        end
        else if (lp_enter_cmd)
            lp_armed <= 1'b0;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (core_reset)
            global_fault_type_o <= `PSC_FLT_RESET;
        else
        begin
            if (rd_status_i && spi_ok)
            begin
                global_fault_type_o[`PSC_FLT_POR_BIT] <= 1'b0;
                global_fault_type_o[`PSC_FLT_LOW_POWER_BIT] <= 1'b0;
                global_fault_type_o[`PSC_FLT_OVERCURRENT_BIT] <= 1'b0;
            end
            global_fault_type_o[`PSC_FLT_VBB_UV_BIT] <= !battery_supply_ok_i;
            global_fault_type_o[`PSC_FLT_FALLBACK_BIT] <= (next_state == psc_pkg::PSC_FALLBACK);
            if (state == psc_pkg::PSC_LOW_POWER && auto_wake)
                global_fault_type_o[`PSC_FLT_LOW_POWER_BIT] <= 1'b1;
            if (state == psc_pkg::PSC_ACTIVE && |(overcurrent_i & on))
                global_fault_type_o[`PSC_FLT_OVERCURRENT_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (core_reset)
            fault_wake_output_n_o <= 1'b1;
        else if (state == psc_pkg::PSC_LOW_POWER && auto_wake)
            fault_wake_output_n_o <= 1'b0;
        else if (rd_status_i && spi_ok && state == psc_pkg::PSC_ACTIVE)
            fault_wake_output_n_o <= 1'b1;
    end

    assign kill = state == psc_pkg::PSC_SLEEP || state == psc_pkg::PSC_INIT
        || state == psc_pkg::PSC_VBB_UV || !battery_supply_ok_i;
    assign freeze = state == psc_pkg::PSC_LP_ENTRY || state == psc_pkg::PSC_LOW_POWER
        || state == psc_pkg::PSC_LP_EXIT;
    assign fallback = state == psc_pkg::PSC_FALLBACK;

    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_ch
        psc_channel u_ch
        (
            .sys_clk_i(sys_clk_i),
            .rst_i(core_reset),
            .kill_i(kill),
            .freeze_i(freeze),
            .fallback_i(fallback),
            .fallback_level_i(fallback_level_i[i]),
            .switch_bit_i(switch_state_o[i]),
            .short_i(short_i[i] && freeze),
            .on_o(on[i])
        );
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_o <= psc_pkg::PSC_SLEEP;
            channel_on_o <= '0;
            spi_ready_o <= 1'b0;
        end
        else
        begin
            state_o <= state;
            channel_on_o <= on;
            spi_ready_o <= spi_ok;
        end
    end

endmodule

// ### src/psc_defines.svh
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// Init plus self-test time after a wake from sleep, in ns
`define PSC_INIT_TIME_NS 400
`define PSC_CLK_PERIOD_NS 4
`define PSC_INIT_CYCLES ((`PSC_INIT_TIME_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
// Self-test time on the way from low power back to active, in ns
`define PSC_ABIST_TIME_NS 200
`define PSC_ABIST_CYCLES ((`PSC_ABIST_TIME_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
// Fields of the global fault-type status word
`define PSC_FLT_POR_BIT 0
`define PSC_FLT_VBB_UV_BIT 1
`define PSC_FLT_FALLBACK_BIT 2
`define PSC_FLT_LOW_POWER_BIT 3
`define PSC_FLT_OVERCURRENT_BIT 4
`define PSC_FLT_WIDTH 5
// Reset values
`define PSC_FLT_RESET 5'h01
`define PSC_WAKE_THR_RESET 2'h0
`define PSC_PAIRING_RESET 1'b0
`define PSC_SWITCH_RESET 2'h0

`endif

// ### src/psc_pkg.sv
package psc_pkg;

    // Gray codes along sleep -> init -> active -> entering -> low power -> exit
    typedef enum logic [2:0] {
        PSC_SLEEP = 3'h0,
        PSC_INIT = 3'h1,
        PSC_ACTIVE = 3'h3,
        PSC_LP_ENTRY = 3'h2,
        PSC_LOW_POWER = 3'h6,
        PSC_LP_EXIT = 3'h7,
        PSC_VBB_UV = 3'h5,
        PSC_FALLBACK = 3'h4
    } psc_state_t;

endpackage

// ### tb/psc_controller_properties.sv
`timescale 1ns/1ns
`include "psc_defines.svh"
module psc_controller_properties
#(
    parameter int CHANNELS = 2
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic battery_supply_ok_i,
    input wire logic logic_supply_ok_i,
    input wire logic fallback_request_input_i,
    input wire logic [CHANNELS-1:0] fully_on_i,
    input wire logic [CHANNELS-1:0] load_above_thr_i,
    input wire logic [CHANNELS-1:0] short_i,
    input wire psc_pkg::psc_state_t state_o,
    input wire logic [CHANNELS-1:0] channel_on_o,
    input wire logic spi_ready_o,
    input wire logic pairing_o,
    input wire logic [`PSC_FLT_WIDTH-1:0] global_fault_type_o,
    input wire logic fault_wake_output_n_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_load_wake;
        state_o == psc_pkg::PSC_LOW_POWER && (|load_above_thr_i);
    endsequence
    sequence s_held_low_power;
        state_o == psc_pkg::PSC_LOW_POWER && !(|short_i) ##1
            state_o == psc_pkg::PSC_LOW_POWER && !(|short_i);
    endsequence
    a_uv_chan_off: assert property ((!battery_supply_ok_i && logic_supply_ok_i)[*3] |-> channel_on_o == '0)
        else $error("channel on during battery undervoltage");
    a_uv_fault_bit: assert property ($rose(state_o == psc_pkg::PSC_VBB_UV) |-> global_fault_type_o[`PSC_FLT_VBB_UV_BIT])
        else $error("battery undervoltage bit not set");
    a_lp_outputs_frozen: assert property (s_held_low_power |-> $stable(channel_on_o))
        else $error("channel changed in low power");
    a_wake_pulls_low: assert property (s_load_wake |-> ##[1:4] !fault_wake_output_n_o)
        else $error("wake output not pulled low");
    a_exit_bounded: assert property (state_o == psc_pkg::PSC_LP_EXIT |-> ##[1:60] state_o == psc_pkg::PSC_ACTIVE)
        else $error("low power exit did not reach active");
    a_pairing_locked: assert property ((|channel_on_o)[*2] |-> $stable(pairing_o))
        else $error("pairing changed with outputs on");
    a_no_spi_state: assert property (state_o inside {psc_pkg::PSC_SLEEP, psc_pkg::PSC_INIT, psc_pkg::PSC_FALLBACK} |-> !spi_ready_o)
        else $error("transfers served while refused");
    a_fallback_entry: assert property (fallback_request_input_i && state_o == psc_pkg::PSC_ACTIVE |-> ##[1:4] state_o == psc_pkg::PSC_FALLBACK)
        else $error("fallback request not taken");
    a_lp_entry_on: assert property ($rose(state_o == psc_pkg::PSC_LOW_POWER) |-> (channel_on_o & ~fully_on_i) == '0)
        else $error("low power entered during inrush");
endmodule
bind psc_controller psc_controller_properties #(.CHANNELS(CHANNELS)) psc_controller_properties_i (.*);

// ### tb/psc_load_model.sv
`timescale 1ns/1ns
// Load side: inrush ends a fixed time after a channel turns on
module psc_load_model
#(
    parameter int INRUSH = 8
)
(
    input wire logic sys_clk_i,
    input wire logic [1:0] on_i,
    output logic [1:0] fully_on_o
);
    int cnt [2];
    always_ff @(posedge sys_clk_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            cnt[c] <= on_i[c] === 1'h1 ? cnt[c] + 1 : 0;
            fully_on_o[c] <= on_i[c] === 1'h1 && cnt[c] >= INRUSH;
        end
    end
endmodule

// ### tb/test_power_state_controller.sv
`timescale 1ns/1ns
`include "psc_defines.svh"
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("wrong value %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module test_power_state_controller;
    logic sys_clk_i = '0, rst_i = '1, select_input_low_i = '1, battery_supply_ok_i = '1;
    logic logic_supply_ok_i = '1, fallback_request_input_i = '0, watchdog_fail_i = '0;
    logic wr_en_i = '0, wr_switch_i = '0, wr_pairing_i = '0, wr_pairing_data_i = '0;
    logic wr_low_power_i = '0, wr_low_power_data_i = '0, wr_fallback_stat_i = '0, rd_status_i = '0;
    logic [1:0] wr_switch_data_i = '0, wr_wake_thr_i = '0, fallback_level_i = '0, fully_on_i;
    logic [1:0] load_above_thr_i = '0, short_i = '0, overcurrent_i = '0;
    logic [1:0] channel_on_o, wake_thr_o, switch_state_o, sw, thr;
    logic spi_ready_o, pairing_o, low_power_bit_o, fault_wake_output_n_o;
    logic [`PSC_FLT_WIDTH-1:0] global_fault_type_o;
    psc_pkg::psc_state_t state_o;
    int n_fail = 0, n_tests = 0;
    psc_controller #(.CHANNELS(2)) psc_controller_i (.*);
    psc_load_model psc_load_model_i (.sys_clk_i(sys_clk_i), .on_i(channel_on_o), .fully_on_o(fully_on_i));
    always #2 sys_clk_i = ~sys_clk_i;
    function automatic logic [4:0] por_word();
        return 5'h01 << `PSC_FLT_POR_BIT;
    endfunction
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic s, p, l, f, input logic [1:0] d);
        @(posedge sys_clk_i) #1;
        {wr_en_i, wr_switch_i, wr_pairing_i, wr_low_power_i, wr_fallback_stat_i} = {1'h1, s, p, l, f};
        {wr_switch_data_i, wr_pairing_data_i, wr_low_power_data_i, wr_wake_thr_i} = {d, d[0], d[0], thr};
        @(posedge sys_clk_i) #1;
        {wr_en_i, wr_switch_i, wr_pairing_i, wr_low_power_i, wr_fallback_stat_i} = '0;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_st(input psc_pkg::psc_state_t s);
        for (int i = 0; i < 400 && state_o !== s; i++) @(posedge sys_clk_i) #1;
        `CHK("state", s, state_o)
        $display("test reaching state %0h done", s);
    endtask
    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h3eabf2ee));
        sw = 2'($urandom_range(3, 1));
        thr = 2'($urandom);
        fallback_level_i = 2'($urandom);
        repeat (8) @(posedge sys_clk_i);
        #1 rst_i = '0;
        `CHK("fault word", por_word(), global_fault_type_o)
        `CHK("state", psc_pkg::PSC_SLEEP, state_o)
        @(posedge sys_clk_i) #1 select_input_low_i = '0;
        @(posedge sys_clk_i) #1 select_input_low_i = '1;
        wait_st(psc_pkg::PSC_ACTIVE);
        `CHK("spi ready", 1'h1, spi_ready_o)
        wr(0, 1, 0, 0, 2'h1);
        `CHK("pairing", 1'h1, pairing_o)
        wr(0, 1, 0, 0, 2'h0);
        wr(1, 0, 0, 0, sw);
        `CHK("switch state", sw, switch_state_o)
        wr(0, 1, 0, 0, 2'h1);
        `CHK("pairing locked", 1'h0, pairing_o)
        `CHK("channels", sw, channel_on_o)
        wr(0, 0, 1, 0, 2'h1);
        wait_st(psc_pkg::PSC_LOW_POWER);
        `CHK("fully on", sw, fully_on_i & sw)
        `CHK("wake threshold", thr, wake_thr_o)
        wr(1, 0, 0, 0, ~sw);
        `CHK("channels frozen", sw, channel_on_o)
        `CHK("stays low power", psc_pkg::PSC_LOW_POWER, state_o)
        load_above_thr_i = sw;
        wait_st(psc_pkg::PSC_ACTIVE);
        `CHK("wake output", 1'h0, fault_wake_output_n_o)
        `CHK("low power bit", 1'h1, low_power_bit_o)
        load_above_thr_i = '0;
        @(posedge sys_clk_i) #1 rd_status_i = '1;
        @(posedge sys_clk_i) #1 rd_status_i = '0;
        repeat (3) @(posedge sys_clk_i);
        #1 `CHK("wake released", 1'h1, fault_wake_output_n_o)
        wr(0, 0, 1, 0, 2'h1);
        `CHK("reentry refused", psc_pkg::PSC_ACTIVE, state_o)
        wr(0, 0, 1, 0, 2'h0);
        wr(0, 0, 1, 0, 2'h1);
        wait_st(psc_pkg::PSC_LOW_POWER);
        wr(0, 0, 1, 0, 2'h0);
        wait_st(psc_pkg::PSC_ACTIVE);
        `CHK("channels kept", sw, channel_on_o)
        `CHK("no overcurrent", 1'h0, global_fault_type_o[`PSC_FLT_OVERCURRENT_BIT])
        @(posedge sys_clk_i) #1 overcurrent_i = sw;
        @(posedge sys_clk_i) #1 overcurrent_i = '0;
        `CHK("overcurrent", 1'h1, global_fault_type_o[`PSC_FLT_OVERCURRENT_BIT])
        fallback_request_input_i = '1;
        wait_st(psc_pkg::PSC_FALLBACK);
        `CHK("fallback bit", 1'h1, global_fault_type_o[`PSC_FLT_FALLBACK_BIT])
        fallback_request_input_i = '0;
        wr(0, 0, 0, 1, 2'h1);
        wait_st(psc_pkg::PSC_ACTIVE);
        battery_supply_ok_i = '0;
        wait_st(psc_pkg::PSC_VBB_UV);
        `CHK("uv channels", 2'h0, channel_on_o)
        `CHK("uv bit", 1'h1, global_fault_type_o[`PSC_FLT_VBB_UV_BIT])
        logic_supply_ok_i = '0;
        wait_st(psc_pkg::PSC_SLEEP);
        `CHK("lost word", por_word(), global_fault_type_o)
        {battery_supply_ok_i, logic_supply_ok_i} = 2'h3;
        close_out();
    end
endmodule
